// >>> hdl/phy_ext_pkg.sv
// Shared constants and types for the extended control register block
package phy_ext_pkg;

    // ****************************************************
    // Register location and field layout
    // ****************************************************
    localparam logic [4:0]  EXT_CTRL_ADDR = 5'h10;
    localparam int          OVR_BIT       = 15;
    localparam int          ADDR_HI       = 10;
    localparam int          ADDR_LO       = 6;
    localparam int          SCR_TEST_BIT  = 5;
    localparam int          NRZI_BIT      = 3;
    localparam int          INV_CODES_BIT = 2;
    localparam int          SCR_DIS_BIT   = 0;
    localparam logic [15:0] RSVD_MASK     = 16'h7812;

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic        OVR_RST       = 1'b0;
    localparam logic        SCR_TEST_RST  = 1'b0;
    localparam logic        NRZI_RST      = 1'b1;
    localparam logic        INV_CODES_RST = 1'b0;
    localparam logic        SCR_DIS_RST   = 1'b0;
    localparam logic [4:0]  PHY_ADDR_RST  = 5'h00;

    // ****************************************************
    // Symbols, cipher seed and lock count
    // ****************************************************
    localparam logic [4:0]  IDLE_SYM      = 5'h1f;
    localparam logic [4:0]  ERR_SYM       = 5'h04;
    localparam logic [10:0] SCR_SEED      = 11'h7ff;
    localparam int          LOCK_IDLES    = 12;

    typedef enum logic {
        LK_HUNT,
        LK_LOCKED
    } lock_state_t;

endpackage : phy_ext_pkg

// >>> hdl/phy_extended_control_reg.sv
// Extended control register of the PHY and its transmit/receive hooks
//
// Operation
// - Setting override enable lets the next write change protected bits.
// - Override enable clears itself after the next management write.
// - Reserved bits 14:11, 4 and 1 read back as zero.
// - Hardware reset latches the five-bit address from LED pins.
// - Software reset leaves the latched address unchanged.
// - Scrambler test bit forces the descrambler to drop lock.
// - At 100 Mbit/s, bit 3 selects NRZ (0) or NRZI (1); reset one.
// - Invalid-codes bit clear gives standard 4B/5B translation always.
// - Forced mode maps nibbles 0-7 to a zero-prefixed code.
// - Forced mode maps nibbles 8-F to the listed alternate codes.
// - Cipher disable bypasses scrambler and descrambler together.
// - Scrambler settings act only at 100 Mbit/s.
`timescale 1ns/10ps
module phy_extended_control_reg #(
    parameter int LOCK_IDLES = phy_ext_pkg::LOCK_IDLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        soft_reset,
    input  wire logic        mgmt_wr,
    input  wire logic        mgmt_rd,
    input  wire logic [4:0]  mgmt_addr,
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata,
    output logic             mgmt_rvalid,
    output logic             override_wr_en,
    output logic             protected_wr_ok,
    input  wire logic [4:0]  led_addr_pins,
    output logic      [4:0]  phy_addr,
    input  wire logic        speed_100,
    input  wire logic [3:0]  txd,
    input  wire logic        tx_en,
    input  wire logic        tx_er,
    output logic      [4:0]  tx_code,
    input  wire logic [4:0]  rx_sym,
    output logic      [4:0]  rx_data,
    output logic             rx_locked
);

    // ****************************************************
    // Register state
    // ****************************************************
    logic        ovr_en_r;
    logic        scr_test_r;
    logic        nrzi_r;
    logic        inv_codes_r;
    logic        scr_dis_r;
    logic [4:0]  phy_addr_r;
    logic        strap_pend_r;
    logic [4:0]  led_s1_r;
    logic [4:0]  led_s2_r;
    logic [15:0] rdata_r;
    logic        rvalid_r;
    logic [4:0]  tx_code_r;
    logic        line_lvl_r;
    logic [4:0]  rx_data_r;
    logic [15:0] reg_value;
    logic        hit;
    logic        wr_hit;
    logic [4:0]  enc_sym;
    logic [4:0]  scr_tx_out;
    logic [4:0]  scr_rx_out;
    logic        scr_bypass;
    logic        scr_test_act;
    logic [5:0]  nrzi_res;

    assign hit    = (mgmt_addr == phy_ext_pkg::EXT_CTRL_ADDR);
    assign wr_hit = mgmt_wr && hit;

    // Read image; reserved positions tied low
    assign reg_value = {ovr_en_r, 4'h0, phy_addr_r,
                        scr_test_r, 1'b0, nrzi_r, inv_codes_r,
                        1'b0, scr_dis_r};

    // ****************************************************
    // Writable fields
    // ****************************************************
    // Software reset restores defaults; reserved data is dropped
    always_ff @(posedge core_clk) begin
        if (!rst_n || soft_reset) begin
            scr_test_r  <= phy_ext_pkg::SCR_TEST_RST;
            nrzi_r      <= phy_ext_pkg::NRZI_RST;
            inv_codes_r <= phy_ext_pkg::INV_CODES_RST;
            scr_dis_r   <= phy_ext_pkg::SCR_DIS_RST;
        end else if (wr_hit) begin
            scr_test_r  <= mgmt_wdata[phy_ext_pkg::SCR_TEST_BIT];
            nrzi_r      <= mgmt_wdata[phy_ext_pkg::NRZI_BIT];
            inv_codes_r <= mgmt_wdata[phy_ext_pkg::INV_CODES_BIT];
            scr_dis_r   <= mgmt_wdata[phy_ext_pkg::SCR_DIS_BIT];
        end
    end

    // Any write consumes the enable; a write setting it wins
    always_ff @(posedge core_clk) begin
        if (!rst_n || soft_reset) begin
            ovr_en_r <= phy_ext_pkg::OVR_RST;
        end else if (mgmt_wr) begin
            ovr_en_r <= wr_hit && mgmt_wdata[phy_ext_pkg::OVR_BIT];
        end
    end

    // Protected bits elsewhere may change only on this qualified write
    assign override_wr_en  = ovr_en_r;
    assign protected_wr_ok = mgmt_wr && ovr_en_r;

    // ****************************************************
    // Address strap
    // ****************************************************
    // LED pins are asynchronous; two stages before use
    always_ff @(posedge core_clk) begin
        led_s1_r <= led_addr_pins;
        led_s2_r <= led_s1_r;
    end

    // Flag armed by reset, used once at the first edge after release
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strap_pend_r <= 1'b1;
        end else begin
            strap_pend_r <= 1'b0;
        end
    end

    // Soft reset is deliberately absent: the address survives it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phy_addr_r <= phy_ext_pkg::PHY_ADDR_RST;
        end else if (strap_pend_r) begin
            phy_addr_r <= led_s2_r;
        end
    end

    assign phy_addr = phy_addr_r;

    // ****************************************************
    // Management read
    // ****************************************************
    // Registered answer one cycle after the strobe; other addresses zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= mgmt_rd;
            if (mgmt_rd) begin
                rdata_r <= hit ? reg_value : 16'h0000;
            end
        end
    end

    assign mgmt_rdata  = rdata_r;
    assign mgmt_rvalid = rvalid_r;

    // ****************************************************
    // Transmit and receive data path
    // ****************************************************
    sym_encoder u_enc (
        .txd          (txd),
        .tx_en        (tx_en),
        .tx_er        (tx_er),
        .inv_codes_en (inv_codes_r),
        .sym          (enc_sym)
    );

    // Cipher is a 100 Mbit/s function only
    assign scr_bypass   = scr_dis_r || !speed_100;
    assign scr_test_act = scr_test_r && speed_100;

    stream_cipher #(
        .LOCK_IDLES (LOCK_IDLES)
    ) u_cipher (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .bypass    (scr_bypass),
        .test_mode (scr_test_act),
        .tx_sym    (enc_sym),
        .rx_sym    (rx_sym),
        .tx_out    (scr_tx_out),
        .rx_out    (scr_rx_out),
        .locked    (rx_locked)
    );

    // Bit 0 leaves first; returns {final level, coded symbol}
    function automatic logic [5:0] nrzi_code(input logic [4:0] d,
                                             input logic       lvl);
        logic       l;
        logic [4:0] o;
        l = lvl;
        o = 5'h00;
        for (int i = 0; i < 5; i++) begin
            l    = l ^ d[i];
            o[i] = l;
        end
        return {l, o};
    endfunction : nrzi_code

    assign nrzi_res = nrzi_code(scr_tx_out, line_lvl_r);

    // Line coding choice only matters in the 100 Mbit/s path
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_code_r  <= 5'h00;
            line_lvl_r <= 1'b0;
        end else if (speed_100 && nrzi_r) begin
            tx_code_r  <= nrzi_res[4:0];
            line_lvl_r <= nrzi_res[5];
        end else begin
            tx_code_r  <= scr_tx_out;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_data_r <= 5'h00;
        end else begin
            rx_data_r <= scr_rx_out;
        end
    end

    assign tx_code = tx_code_r;
    assign rx_data = rx_data_r;

    // ****************************************************
    // Checks
    // ****************************************************
    sequence s_arm;
        wr_hit && mgmt_wdata[phy_ext_pkg::OVR_BIT] && !soft_reset;
    endsequence

    sequence s_consume;
        mgmt_wr && !(wr_hit && mgmt_wdata[phy_ext_pkg::OVR_BIT]);
    endsequence

    property p_ovr_set;
        @(posedge core_clk) disable iff (!rst_n)
        s_arm |=> override_wr_en;
    endproperty
    a_ovr_set: assert property (p_ovr_set)
        else $error("override enable not set by write");

    property p_ovr_once;
        @(posedge core_clk) disable iff (!rst_n)
        override_wr_en ##0 s_consume |=> !override_wr_en && !protected_wr_ok;
    endproperty
    a_ovr_once: assert property (p_ovr_once)
        else $error("override enable survived the next write");

    property p_prot_gate;
        @(posedge core_clk) disable iff (!rst_n)
        mgmt_wr && !override_wr_en |-> !protected_wr_ok;
    endproperty
    a_prot_gate: assert property (p_prot_gate)
        else $error("protected write allowed without enable");

    property p_rsvd_zero;
        @(posedge core_clk) disable iff (!rst_n)
        mgmt_rvalid |-> (mgmt_rdata & phy_ext_pkg::RSVD_MASK) == 16'h0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bit read as one");

    property p_strap;
        @(posedge core_clk) disable iff (!rst_n)
        strap_pend_r |=> phy_addr == $past(led_s2_r) ##1 phy_addr ==
                         $past(phy_addr) || $past(strap_pend_r);
    endproperty
    a_strap: assert property (p_strap)
        else $error("address not latched from strap");

    property p_addr_soft;
        @(posedge core_clk) disable iff (!rst_n)
        soft_reset && !strap_pend_r |=> phy_addr == $past(phy_addr);
    endproperty
    a_addr_soft: assert property (p_addr_soft)
        else $error("software reset changed address");

    property p_nrz;
        @(posedge core_clk) disable iff (!rst_n)
        (speed_100 && !nrzi_r) || !speed_100 |=>
            tx_code == $past(scr_tx_out);
    endproperty
    a_nrz: assert property (p_nrz)
        else $error("NRZ output differs from symbol");

    property p_std_code;
        @(posedge core_clk) disable iff (!rst_n)
        !inv_codes_r && tx_en && txd == 4'h0 && !tx_er |->
            enc_sym == 5'h1e;
    endproperty
    a_std_code: assert property (p_std_code)
        else $error("standard translation not applied");

    property p_inv_code;
        @(posedge core_clk) disable iff (!rst_n)
        inv_codes_r && tx_er |-> enc_sym[4] == 1'b0 || txd[3];
    endproperty
    a_inv_code: assert property (p_inv_code)
        else $error("forced code high bit wrong for low nibble");

    property p_bypass;
        @(posedge core_clk) disable iff (!rst_n)
        scr_bypass |-> scr_tx_out == enc_sym && scr_rx_out == rx_sym;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("cipher not bypassed");

endmodule : phy_extended_control_reg

// >>> hdl/stream_cipher.sv
// Symbol-wide transmit scrambler and self-locking receive descrambler
`timescale 1ns/10ps
module stream_cipher #(
    parameter int LOCK_IDLES = phy_ext_pkg::LOCK_IDLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       bypass,
    input  wire logic       test_mode,
    input  wire logic [4:0] tx_sym,
    input  wire logic [4:0] rx_sym,
    output logic      [4:0] tx_out,
    output logic      [4:0] rx_out,
    output logic            locked
);

    // ****************************************************
    // Key generator, x^11 + x^9 + 1
    // ****************************************************
    // State holds the last eleven key bits; returns {key, next state}
    function automatic logic [15:0] key_step(input logic [10:0] s);
        logic [10:0] t;
        logic [4:0]  k;
        t = s;
        k = 5'h00;
        for (int i = 0; i < 5; i++) begin
            k[i] = t[10] ^ t[8];
            t    = {t[9:0], k[i]};
        end
        return {k, t};
    endfunction : key_step

    logic [10:0]                   tx_lfsr_r;
    logic [10:0]                   rx_lfsr_r;
    logic [$clog2(LOCK_IDLES+1)-1:0] match_cnt_r;
    phy_ext_pkg::lock_state_t      lock_r;
    logic [15:0]                   tx_step;
    logic [15:0]                   rx_step;
    logic [4:0]                    rx_key_obs;
    logic                          rx_match;

    assign tx_step    = key_step(tx_lfsr_r);
    assign rx_step    = key_step(rx_lfsr_r);
    assign rx_key_obs = ~rx_sym;          // idle is all ones
    // An all-zero state never counts: plain idles would lock on it
    assign rx_match   = (rx_lfsr_r != '0) && (rx_step[15:11] == rx_key_obs);
    assign locked     = (lock_r == phy_ext_pkg::LK_LOCKED);

    // Bypass sends plain symbols both ways
    assign tx_out = bypass ? tx_sym : (tx_sym ^ tx_step[15:11]);
    assign rx_out = bypass ? rx_sym : (rx_sym ^ rx_step[15:11]);

    // Transmit key advances every symbol
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_lfsr_r <= phy_ext_pkg::SCR_SEED;
        end else begin
            tx_lfsr_r <= tx_step[10:0];
        end
    end

    // Hunting loads key bits seen on idle, oldest bit highest as the
    // generator shifts them in; locked free-runs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_lfsr_r <= phy_ext_pkg::SCR_SEED;
        end else if (lock_r == phy_ext_pkg::LK_HUNT) begin
            rx_lfsr_r <= {rx_lfsr_r[5:0], rx_key_obs[0], rx_key_obs[1],
                          rx_key_obs[2], rx_key_obs[3], rx_key_obs[4]};
        end else begin
            rx_lfsr_r <= rx_step[10:0];
        end
    end

    // Lock after a run of predicted idles; test mode or bypass drops lock
    always_ff @(posedge core_clk) begin
        if (!rst_n || test_mode || bypass) begin
            lock_r      <= phy_ext_pkg::LK_HUNT;
            match_cnt_r <= '0;
        end else begin
            unique case (lock_r)
                phy_ext_pkg::LK_HUNT: begin
                    if (!rx_match) begin
                        match_cnt_r <= '0;
                    end else if (int'(match_cnt_r) == LOCK_IDLES - 1) begin
                        lock_r <= phy_ext_pkg::LK_LOCKED;
                    end else begin
                        match_cnt_r <= match_cnt_r + 1'b1;
                    end
                end
                phy_ext_pkg::LK_LOCKED: begin
                    match_cnt_r <= '0;
                end
            endcase
        end
    end

    // Test mode leaves the receiver hunting on the next edge
    property p_test_unlocks;
        @(posedge core_clk) disable iff (!rst_n)
        test_mode |=> !locked;
    endproperty
    a_test_unlocks: assert property (p_test_unlocks)
        else $error("descrambler kept lock in test mode");

endmodule : stream_cipher

// >>> hdl/sym_encoder.sv
// 4B/5B transmit symbol encoder with forced invalid-code table
`timescale 1ns/10ps
module sym_encoder (
    input  wire logic [3:0] txd,
    input  wire logic       tx_en,
    input  wire logic       tx_er,
    input  wire logic       inv_codes_en,
    output logic      [4:0] sym
);

    // ****************************************************
    // Code tables
    // ****************************************************
    // Standard nibble to symbol translation
    function automatic logic [4:0] std_code(input logic [3:0] n);
        unique case (n)
            4'h0: std_code = 5'h1e;
            4'h1: std_code = 5'h09;
            4'h2: std_code = 5'h14;
            4'h3: std_code = 5'h15;
            4'h4: std_code = 5'h0a;
            4'h5: std_code = 5'h0b;
            4'h6: std_code = 5'h0e;
            4'h7: std_code = 5'h0f;
            4'h8: std_code = 5'h12;
            4'h9: std_code = 5'h13;
            4'ha: std_code = 5'h16;
            4'hb: std_code = 5'h17;
            4'hc: std_code = 5'h1a;
            4'hd: std_code = 5'h1b;
            4'he: std_code = 5'h1c;
            4'hf: std_code = 5'h1d;
        endcase
    endfunction : std_code

    // Forced table: low half is the nibble with a zero on top
    function automatic logic [4:0] inv_code(input logic [3:0] n);
        unique case (n[3])
            1'b0: inv_code = {1'b0, n};
            1'b1: begin
                unique case (n[2:0])
                    3'h0: inv_code = 5'h00;
                    3'h1: inv_code = 5'h0d;
                    3'h2: inv_code = 5'h0c;
                    3'h3: inv_code = 5'h11;
                    3'h4: inv_code = 5'h10;
                    3'h5: inv_code = 5'h19;
                    3'h6: inv_code = 5'h18;
                    3'h7: inv_code = 5'h1f;
                endcase
            end
        endcase
    endfunction : inv_code

    // Forced table wins only while enabled and the MAC flags an error
    always_comb begin
        if (inv_codes_en && tx_er) begin
            sym = inv_code(txd);
        end else if (!tx_en) begin
            sym = phy_ext_pkg::IDLE_SYM;
        end else if (tx_er) begin
            sym = phy_ext_pkg::ERR_SYM;
        end else begin
            sym = std_code(txd);
        end
    end

endmodule : sym_encoder

// >>> sim/sta_model.sv
// Station and MAC model: management accesses, transmit nibbles, line loop
`timescale 1ns/10ps
module sta_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] mgmt_rdata,
    input  wire logic        mgmt_rvalid,
    input  wire logic        protected_wr_ok,
    input  wire logic [4:0]  tx_code,
    output logic             mgmt_wr,
    output logic             mgmt_rd,
    output logic      [4:0]  mgmt_addr,
    output logic      [15:0] mgmt_wdata,
    output logic      [3:0]  txd,
    output logic             tx_en,
    output logic             tx_er,
    output logic      [4:0]  rx_sym
);
    // ****************************************************
    // Idle levels and line loopback
    // ****************************************************
    logic ok_seen;

    // Strobes idle low; stream idles until the bench asks otherwise
    initial begin
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_addr = 5'h00;
        mgmt_wdata = 16'h0000;
        txd = 4'h0;
        tx_en = 1'b0;
        tx_er = 1'b0;
        rx_sym = 5'h00;
        ok_seen = 1'b0;
    end

    // Our own line symbols come back half a cycle late, a far end echoing
    always @(negedge core_clk) begin
        rx_sym <= tx_code;
    end

    // ****************************************************
    // Access tasks, entered and left at a falling edge
    // ****************************************************
    // Reserved positions always carry their default of zero
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge core_clk);
        mgmt_addr = a;
        mgmt_wdata = d & ~phy_ext_pkg::RSVD_MASK;
        mgmt_wr = 1'b1;
        #2;
        ok_seen = protected_wr_ok;
        @(negedge core_clk);
        mgmt_wr = 1'b0;
    endtask : wr

    // Read answer lands one edge after the strobe is taken
    task automatic rd(input logic [4:0] a, output logic [15:0] d,
                      output logic ok);
        @(negedge core_clk);
        mgmt_addr = a;
        mgmt_rd = 1'b1;
        @(negedge core_clk);
        mgmt_rd = 1'b0;
        ok = mgmt_rvalid;
        d = mgmt_rdata;
    endtask : rd

    // One nibble in, its line symbol sampled at the next falling edge
    task automatic send(input logic [3:0] n, input logic en, input logic er,
                        output logic [4:0] code);
        txd = n;
        tx_en = en;
        tx_er = er;
        @(negedge core_clk);
        code = tx_code;
    endtask : send
endmodule : sta_model

// >>> sim/tb_phy_extended_control_reg.sv
// Self-checking bench for the extended control register block
`timescale 1ns/10ps
module tb_phy_extended_control_reg;
    // ****************************************************
    // Signals, instances and helpers
    // ****************************************************
    logic        core_clk;
    logic        rst_n;
    logic        soft_reset;
    logic [4:0]  led_addr_pins;
    logic        speed_100;
    logic        mgmt_wr;
    logic        mgmt_rd;
    logic [4:0]  mgmt_addr;
    logic [15:0] mgmt_wdata;
    logic [15:0] mgmt_rdata;
    logic        mgmt_rvalid;
    logic        override_wr_en;
    logic        protected_wr_ok;
    logic [4:0]  phy_addr;
    logic [3:0]  txd;
    logic        tx_en;
    logic        tx_er;
    logic [4:0]  tx_code;
    logic [4:0]  rx_sym;
    logic [4:0]  rx_data;
    logic        rx_locked;
    int          mismatches;
    int          cmp_count;
    logic [15:0] d;
    logic        v;
    logic [4:0]  c0;
    logic [4:0]  c1;
    int          n_diff;
    // Forced error table and standard nibble codes
    logic [4:0] ftab [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
        5'h06, 5'h07, 5'h00, 5'h0d, 5'h0c, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1f};
    logic [4:0] stab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
        5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    phy_extended_control_reg #(.LOCK_IDLES(3)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .soft_reset(soft_reset),
        .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .override_wr_en(override_wr_en),
        .protected_wr_ok(protected_wr_ok), .led_addr_pins(led_addr_pins),
        .phy_addr(phy_addr), .speed_100(speed_100), .txd(txd),
        .tx_en(tx_en), .tx_er(tx_er), .tx_code(tx_code), .rx_sym(rx_sym),
        .rx_data(rx_data), .rx_locked(rx_locked));

    sta_model u_sta (
        .core_clk(core_clk), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .protected_wr_ok(protected_wr_ok),
        .tx_code(tx_code), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
        .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .txd(txd),
        .tx_en(tx_en), .tx_er(tx_er), .rx_sym(rx_sym));

    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Hang guard at 50000 cycles, far beyond the whole run
    initial begin
        #400000;
        mismatches++;
        stop_test();
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Line level flips on each one, starting from the last level sent
    function automatic logic [4:0] nrzi(input logic [4:0] s, input logic lv);
        logic [4:0] o;
        for (int i = 0; i < 5; i++) begin
            lv = lv ^ s[i];
            o[i] = lv;
        end
        return o;
    endfunction : nrzi

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        mismatches = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        soft_reset = 1'b0;
        led_addr_pins = 5'h15;
        speed_100 = 1'b0;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        chk(16'(phy_addr), 16'h0015);
        u_sta.rd(5'h10, d, v);
        chk(16'(v), 16'h0001);
        chk(d, 16'h0548);
        // Everything writable set, reserved and address bits refused
        u_sta.wr(5'h10, 16'hffff);
        u_sta.rd(5'h10, d, v);
        chk(d, 16'h856d);
        chk(16'(override_wr_en), 16'h0001);
        u_sta.wr(5'h01, 16'h0000);
        chk(16'(u_sta.ok_seen), 16'h0001);
        chk(16'(override_wr_en), 16'h0000);
        u_sta.wr(5'h01, 16'h0000);
        chk(16'(u_sta.ok_seen), 16'h0000);
        u_sta.rd(5'h10, d, v);
        chk(d, 16'h056d);
        // Software reset must not reload the strapped address
        led_addr_pins = 5'h0a;
        soft_reset = 1'b1;
        @(negedge core_clk);
        soft_reset = 1'b0;
        chk(16'(phy_addr), 16'h0015);
        u_sta.rd(5'h10, d, v);
        chk(d, 16'h0548);
        // 10 Mbit/s, so the cipher stays out of the way
        for (int b = 0; b < 2; b++) begin
            u_sta.wr(5'h10, b ? 16'h0004 : 16'h0000);
            for (int n = 0; n < 16; n++) begin
                u_sta.send(4'(n), 1'b1, 1'b0, c0);
                chk(16'(c0), 16'(stab[n]));
                if (b == 1) begin
                    u_sta.send(4'(n), 1'b1, 1'b1, c0);
                    chk(16'(c0), 16'(ftab[n]));
                end
            end
        end
        // Line coding at 100 Mbit/s with the cipher bypassed
        speed_100 = 1'b1;
        u_sta.wr(5'h10, 16'h0009);
        u_sta.send(4'hf, 1'b0, 1'b0, c0);
        u_sta.send(4'hf, 1'b0, 1'b0, c1);
        chk(16'(c1), 16'(nrzi(5'h1f, c0[4])));
        u_sta.wr(5'h10, 16'h0001);
        u_sta.send(4'hf, 1'b0, 1'b0, c0);
        chk(16'(c0), 16'h001f);
        // Cipher on: idles must leave scrambled
        u_sta.wr(5'h10, 16'h0000);
        n_diff = 0;
        for (int i = 0; i < 8; i++) begin
            u_sta.send(4'hf, 1'b0, 1'b0, c0);
            if (c0 !== 5'h1f) begin
                n_diff++;
            end
        end
        chk(16'(n_diff != 0), 16'h0001);
        // Echoed idles let the descrambler lock, bounded wait
        for (int i = 0; i < 200 && rx_locked !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        chk(16'(rx_locked), 16'h0001);
        chk(16'(rx_data), 16'h001f);
        u_sta.wr(5'h10, 16'h0020);
        @(negedge core_clk);
        for (int i = 0; i < 8; i++) begin
            chk(16'(rx_locked), 16'h0000);
            @(negedge core_clk);
        end
        stop_test();
    end
endmodule : tb_phy_extended_control_reg
